// *** common/dcas_params.svh ***
// Named constants for the dual channel allegiance switch
`ifndef DCAS_PARAMS_SVH
`define DCAS_PARAMS_SVH

// ==========================================================
// Status byte codes
`define DCAS_ST_DEV_BUSY 8'h10
`define DCAS_ST_CU_BUSY 8'h70
`define DCAS_ST_DEV_END 8'h04
`define DCAS_ST_BUSY_BIT 8'h10
`define DCAS_ST_NONE 8'h00

// ==========================================================
// Per-interface vector constants
`define DCAS_NONE2 2'b00
`define DCAS_BOTH2 2'b11

`endif

// *** common/dcas_pkg.sv ***
// Types shared by the allegiance switch modules
package dcas_pkg;

  // ==========================================================
  // Allegiance states
  typedef enum logic [2:0] {
    DCAS_NEUTRAL = 3'b000,
    DCAS_SHORT = 3'b001,
    DCAS_LONG = 3'b010,
    DCAS_CONTINGENT = 3'b011,
    DCAS_UNTAGGED = 3'b100,
    DCAS_TAGGED = 3'b101
  } dcas_state_t;

  // ==========================================================
  // Core state record
  typedef struct packed {
    dcas_state_t state;
    logic owner;
    logic [1:0] held;
    logic [1:0] busied;
    logic [1:0] dis;
    logic isel_int;
    logic ds_int;
    logic ds_srst;
    logic async_pend;
    logic async_go;
    logic [7:0] async_val;
    logic [1:0] req_in;
    logic [1:0] bypass;
    logic [1:0] trap;
    logic [1:0] connect;
    logic [7:0] status;
    logic stat_valid;
    logic adp_reset;
    logic [1:0] de_set;
    logic [1:0] de_clr;
  } dcas_core_t;

  typedef struct packed {
    logic prev;
    logic rise_init;
    logic rise_poll;
  } dcas_side_t;

endpackage

// *** common/dcas_lane_if.sv ***
// Per-interface carrier between the core and its helpers
`timescale 1ns/1ps
interface dcas_lane_if;
  logic sel_out;
  logic chan_init;
  logic rise_init;
  logic rise_poll;
  logic de_set;
  logic de_clr;
  logic de_pend;
  modport det (input sel_out, input chan_init, output rise_init, output rise_poll);
  modport flag (input de_set, input de_clr, output de_pend);
endinterface

// *** logic/dcas_side.sv ***
// Select Out rise detector for one channel interface
`timescale 1ns/1ps
module dcas_side
  import dcas_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  dcas_lane_if.det lane
);
  dcas_side_t st_r;
  dcas_side_t st_nxt;

  // ==========================================================
  // Rise classified as poll or channel-initiated selection
  always_comb begin
    st_nxt = st_r;
    st_nxt.prev = lane.sel_out;
    st_nxt.rise_init = lane.sel_out & ~st_r.prev & lane.chan_init;
    st_nxt.rise_poll = lane.sel_out & ~st_r.prev & ~lane.chan_init;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign lane.rise_init = st_r.rise_init;
  assign lane.rise_poll = st_r.rise_poll;

  property p_rise;
    @(posedge clock) disable iff (!resetn)
      (lane.sel_out && !st_r.prev && lane.chan_init) |=> lane.rise_init;
  endproperty
  a_rise: assert property (p_rise) else $error("Select Out rise not seen");
endmodule

// *** logic/dcas_de_flag.sv ***
// Pending tagged Device End flag for one interface
`timescale 1ns/1ps
module dcas_de_flag (
  input wire logic clock,
  input wire logic resetn,
  dcas_lane_if.flag lane
);
  typedef struct packed {
    logic pend;
  } dcas_flag_t;

  dcas_flag_t st_r;
  dcas_flag_t st_nxt;

  // A set in the same cycle as a clear wins, so no owed Device End is lost
  always_comb begin
    st_nxt = st_r;
    if (lane.de_clr) begin
      st_nxt.pend = 1'b0;
    end
    if (lane.de_set) begin
      st_nxt.pend = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign lane.de_pend = st_r.pend;

  property p_flag;
    @(posedge clock) disable iff (!resetn)
      (lane.de_clr && !lane.de_set) |=> !lane.de_pend ##1 (lane.de_pend || !lane.de_set);
  endproperty
  a_flag: assert property (p_flag) else $error("Device End flag clear failed");
endmodule

// *** logic/dcas_switch.sv ***
// Allegiance, status routing and reset handling for a two-interface adapter
`timescale 1ns/1ps
`include "dcas_params.svh"

module dcas_switch
  import dcas_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic [1:0] if_enabled,
  input wire logic [1:0] sel_out,
  input wire logic [1:0] chan_init,
  input wire logic cmd_accepted,
  input wire logic cmd_is_tio,
  input wire logic noop_unchained,
  input wire logic zero_status_xfer,
  input wire logic last_de_accepted,
  input wire logic unit_check_end,
  input wire logic ctl_cmd_decoded,
  input wire logic status_accepted,
  input wire logic status_stacked,
  input wire logic async_setup,
  input wire logic async_start,
  input wire logic [7:0] async_status,
  input wire logic prog_int_pending,
  input wire logic isel_int_clear,
  input wire logic ds_int_clear,
  input wire logic [1:0] allow_disable,
  input wire logic [1:0] panel_off,
  input wire logic [1:0] sys_reset,
  input wire logic [1:0] sel_reset,
  output logic [1:0] req_in,
  output logic [1:0] sel_bypass,
  output logic [1:0] sel_trap,
  output logic [1:0] connect,
  output logic [7:0] status_byte,
  output logic status_valid,
  output logic isel_int_req,
  output logic ds_int_req,
  output logic adapter_reset,
  output logic [2:0] allegiance,
  output logic [1:0] de_pending
);
  dcas_core_t st_r;
  dcas_core_t st_nxt;
  logic [1:0] rise_init;
  logic [1:0] rise_poll;
  logic [1:0] de_pend;
  logic [1:0] de_live;
  logic st_done;

  // ==========================================================
  // Helper functions
  // Lower interface wins a tie; both channels see the same fixed order
  function automatic logic dcas_pick(input logic [1:0] v);
    return ~v[0];
  endfunction

  function automatic logic [1:0] dcas_oh(input logic i);
    return {i, ~i};
  endfunction

  // Full adapter reset keeps owed Device Ends, including a busied side not yet flagged, except on a dual system reset
  function automatic dcas_core_t dcas_full_reset(input dcas_core_t s);
    dcas_core_t r;
    r = '0;
    r.de_set = s.de_set | (s.busied & ~s.dis);
    r.adp_reset = 1'b1;
    r.isel_int = 1'b1;
    return r;
  endfunction

  // ==========================================================
  // Per-interface helpers
  dcas_lane_if lane [2] ();

  generate
    for (genvar g = 0; g < 2; g++) begin : g_lane
      assign lane[g].sel_out = sel_out[g];
      assign lane[g].chan_init = chan_init[g];
      assign lane[g].de_set = st_r.de_set[g];
      assign lane[g].de_clr = st_r.de_clr[g];
      assign rise_init[g] = lane[g].rise_init;
      assign rise_poll[g] = lane[g].rise_poll;
      assign de_pend[g] = lane[g].de_pend;
      dcas_side u_side (
        .clock(clock),
        .resetn(resetn),
        .lane(lane[g])
      );
      dcas_de_flag u_flag (
        .clock(clock),
        .resetn(resetn),
        .lane(lane[g])
      );
    end
  endgenerate

  assign st_done = status_accepted | status_stacked;

  // A flag still being cleared by the flop must not start a second presentation
  assign de_live = de_pend & ~st_r.de_clr;

  // ==========================================================
  // Next-state logic; resets are applied last so they take priority
  always_comb begin
    logic i;
    logic oth;
    logic own;
    st_nxt = st_r;
    i = 1'b0;
    own = st_r.owner;
    oth = ~st_r.owner;
    st_nxt.stat_valid = 1'b0;
    st_nxt.adp_reset = 1'b0;
    st_nxt.de_set = `DCAS_NONE2;
    st_nxt.de_clr = `DCAS_NONE2;
    st_nxt.bypass = `DCAS_NONE2;
    // Interrupt latches: a clear loses to a set later in this process
    if (isel_int_clear) begin
      st_nxt.isel_int = 1'b0;
    end
    if (ds_int_clear) begin
      st_nxt.ds_int = 1'b0;
      st_nxt.ds_srst = 1'b0;
    end
    if (async_setup) begin
      st_nxt.async_pend = 1'b1;
      st_nxt.async_val = async_status;
    end
    if (async_start) begin
      st_nxt.async_go = 1'b1;
    end
    unique case (st_r.state)
      DCAS_NEUTRAL: begin
        // Selection or data/status interrupt outstanding: polls are not answered
        if (st_r.isel_int || st_r.ds_int) begin
          st_nxt.bypass = rise_poll;
        end
        if (st_r.held != `DCAS_NONE2) begin
          i = dcas_pick(st_r.held);
          st_nxt.held[i] = 1'b0;
          st_nxt.trap[i] = 1'b0;
          st_nxt.state = DCAS_SHORT;
          st_nxt.owner = i;
          st_nxt.connect = dcas_oh(i);
        end else if (rise_init != `DCAS_NONE2) begin
          i = dcas_pick(rise_init);
          if (st_r.isel_int) begin
            st_nxt.status = `DCAS_ST_CU_BUSY;
            st_nxt.stat_valid = 1'b1;
          end else if (st_r.async_pend) begin
            st_nxt.status = st_r.async_val | (cmd_is_tio ? `DCAS_ST_NONE : `DCAS_ST_BUSY_BIT);
            st_nxt.stat_valid = 1'b1;
            st_nxt.isel_int = 1'b1;
          end else begin
            st_nxt.state = DCAS_SHORT;
            st_nxt.owner = i;
            st_nxt.connect = dcas_oh(i);
          end
        end else if (de_live != `DCAS_NONE2 && !st_r.isel_int && !st_r.ds_srst
                     && !prog_int_pending) begin
          // Owed Device End goes only to its own interface
          i = dcas_pick(de_live);
          st_nxt.state = DCAS_TAGGED;
          st_nxt.owner = i;
          st_nxt.req_in = dcas_oh(i);
          st_nxt.status = `DCAS_ST_DEV_END | (st_r.async_pend ? st_r.async_val : `DCAS_ST_NONE);
          st_nxt.async_pend = async_setup;
        end else if (st_r.async_go && st_r.async_pend && if_enabled != `DCAS_NONE2) begin
          st_nxt.state = DCAS_UNTAGGED;
          st_nxt.async_go = async_start;
          st_nxt.req_in = if_enabled;
          st_nxt.status = st_r.async_val;
        end
      end
      DCAS_SHORT: begin
        if (rise_init[oth]) begin
          st_nxt.held[oth] = 1'b1;
          st_nxt.trap[oth] = 1'b1;
        end
        if (cmd_accepted || zero_status_xfer) begin
          st_nxt.state = DCAS_LONG;
          if (st_r.held[oth] || rise_init[oth]) begin
            st_nxt.status = `DCAS_ST_DEV_BUSY;
            st_nxt.stat_valid = 1'b1;
            st_nxt.held[oth] = 1'b0;
            st_nxt.trap[oth] = 1'b0;
            st_nxt.busied[oth] = 1'b1;
          end
        end else if (unit_check_end) begin
          st_nxt.state = DCAS_CONTINGENT;
        end else if (noop_unchained || st_done) begin
          st_nxt.state = DCAS_NEUTRAL;
          st_nxt.connect = `DCAS_NONE2;
        end
      end
      DCAS_LONG, DCAS_CONTINGENT: begin
        if (rise_init[oth]) begin
          st_nxt.status = `DCAS_ST_DEV_BUSY;
          st_nxt.stat_valid = 1'b1;
          st_nxt.busied[oth] = 1'b1;
        end
        st_nxt.dis = st_r.dis | allow_disable | panel_off;
        if (st_r.state == DCAS_LONG && unit_check_end) begin
          st_nxt.state = DCAS_CONTINGENT;
        end else if ((st_r.state == DCAS_LONG && last_de_accepted) ||
                     (st_r.state == DCAS_CONTINGENT && ctl_cmd_decoded)) begin
          // Disable seen before neutral cancels the owed Device End
          st_nxt.state = DCAS_NEUTRAL;
          st_nxt.connect = `DCAS_NONE2;
          st_nxt.de_set = st_r.busied & ~st_nxt.dis;
          st_nxt.busied = `DCAS_NONE2;
          st_nxt.dis = `DCAS_NONE2;
        end
      end
      DCAS_UNTAGGED, DCAS_TAGGED: begin
        if (st_r.connect == `DCAS_NONE2) begin
          // Untagged: first poller; tagged: only the owed interface
          if (st_r.state == DCAS_UNTAGGED && rise_poll != `DCAS_NONE2) begin
            i = dcas_pick(rise_poll);
            st_nxt.owner = i;
            st_nxt.connect = dcas_oh(i);
            st_nxt.req_in = `DCAS_NONE2;
            st_nxt.stat_valid = 1'b1;
          end else if (st_r.state == DCAS_TAGGED && rise_poll[own]) begin
            st_nxt.connect = dcas_oh(own);
            st_nxt.req_in = `DCAS_NONE2;
            st_nxt.stat_valid = 1'b1;
          end
          if (st_r.state == DCAS_TAGGED) begin
            st_nxt.bypass[oth] = rise_poll[oth];
          end
        end else begin
          st_nxt.bypass[oth] = rise_poll[oth];
          if (st_done) begin
            st_nxt.state = DCAS_NEUTRAL;
            st_nxt.connect = `DCAS_NONE2;
            if (st_r.state == DCAS_UNTAGGED) begin
              st_nxt.ds_int = 1'b1;
              st_nxt.async_pend = status_stacked | async_setup;
            end else begin
              st_nxt.de_clr[own] = 1'b1;
            end
          end
        end
        if (rise_init[oth]) begin
          st_nxt.held[oth] = 1'b1;
          st_nxt.trap[oth] = 1'b1;
        end
      end
    endcase
    // Selective reset: only the interface holding allegiance counts
    if (sel_reset[own] && st_r.state != DCAS_NEUTRAL) begin
      st_nxt.state = DCAS_NEUTRAL;
      st_nxt.connect = `DCAS_NONE2;
      st_nxt.req_in = `DCAS_NONE2;
      st_nxt.de_clr[own] = 1'b1;
      st_nxt.busied[own] = 1'b0;
      if (st_r.state == DCAS_UNTAGGED || st_r.state == DCAS_TAGGED) begin
        st_nxt.ds_int = 1'b1;
        st_nxt.ds_srst = 1'b1;
      end else begin
        st_nxt.isel_int = 1'b1;
      end
    end
    // Selective reset on the other side falls through untouched
    // System reset: both sides, or the owner outside neutral, reset all, else clear own flag
    if (sys_reset == `DCAS_BOTH2) begin
      st_nxt = dcas_full_reset(st_nxt);
      st_nxt.de_set = `DCAS_NONE2;
      st_nxt.de_clr = `DCAS_BOTH2;
    end else if (sys_reset[own] && st_r.state != DCAS_NEUTRAL) begin
      st_nxt = dcas_full_reset(st_nxt);
      st_nxt.de_clr = `DCAS_NONE2;
    end else if (sys_reset != `DCAS_NONE2) begin
      i = dcas_pick(sys_reset);
      st_nxt.de_clr[i] = 1'b1;
      st_nxt.de_set[i] = 1'b0;
      st_nxt.busied[i] = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // Outputs, each a flop of the state record except de_pending, which comes from the flag helpers
  assign req_in = st_r.req_in;
  assign sel_bypass = st_r.bypass;
  assign sel_trap = st_r.trap;
  assign connect = st_r.connect;
  assign status_byte = st_r.status;
  assign status_valid = st_r.stat_valid;
  assign isel_int_req = st_r.isel_int;
  assign ds_int_req = st_r.ds_int;
  assign adapter_reset = st_r.adp_reset;
  assign allegiance = st_r.state;
  assign de_pending = de_pend;

  // ==========================================================
  // Checks
  property p_hold;
    @(posedge clock) disable iff (!resetn)
      (st_r.state == DCAS_SHORT && rise_init[~st_r.owner] && !cmd_accepted
       && !zero_status_xfer && sys_reset == 2'b00 && sel_reset == 2'b00)
      |=> (st_r.trap != 2'b00);
  endproperty
  a_hold: assert property (p_hold) else $error("Opposite selection not held");

  property p_busy;
    @(posedge clock) disable iff (!resetn)
      (st_r.state == DCAS_LONG && rise_init[~st_r.owner] && sys_reset == 2'b00)
      |=> status_valid && status_byte == `DCAS_ST_DEV_BUSY;
  endproperty
  a_busy: assert property (p_busy) else $error("Device busy not given");

  property p_cubusy;
    @(posedge clock) disable iff (!resetn)
      (st_r.state == DCAS_NEUTRAL && st_r.isel_int && st_r.held == 2'b00
       && rise_init != 2'b00 && sys_reset == 2'b00)
      |=> status_valid && status_byte == `DCAS_ST_CU_BUSY && allegiance == DCAS_NEUTRAL;
  endproperty
  a_cubusy: assert property (p_cubusy) else $error("Control unit busy not given");

  property p_untag;
    @(posedge clock) disable iff (!resetn)
      (allegiance == DCAS_UNTAGGED && connect == 2'b00) |-> req_in == if_enabled;
  endproperty
  a_untag: assert property (p_untag) else $error("Untagged status not offered");

  property p_dsint;
    @(posedge clock) disable iff (!resetn)
      (st_r.state == DCAS_UNTAGGED && st_r.connect != 2'b00 && st_done
       && sys_reset == 2'b00 && sel_reset == 2'b00)
      |=> ds_int_req && allegiance == DCAS_NEUTRAL ##1 (ds_int_req || $past(ds_int_clear));
  endproperty
  a_dsint: assert property (p_dsint) else $error("Data/status interrupt missing");

  property p_sys2;
    @(posedge clock) disable iff (!resetn)
      sys_reset == 2'b11 |=> adapter_reset && isel_int_req && allegiance == DCAS_NEUTRAL
        ##1 !adapter_reset;
  endproperty
  a_sys2: assert property (p_sys2) else $error("Dual system reset mishandled");

  property p_selown;
    @(posedge clock) disable iff (!resetn)
      (st_r.state inside {DCAS_SHORT, DCAS_LONG, DCAS_CONTINGENT} && sel_reset[st_r.owner]
       && sys_reset == 2'b00)
      |=> isel_int_req && allegiance == DCAS_NEUTRAL && connect == 2'b00;
  endproperty
  a_selown: assert property (p_selown) else $error("Selective reset on owner missed");

  property p_selother;
    @(posedge clock) disable iff (!resetn)
      (st_r.state inside {DCAS_LONG, DCAS_CONTINGENT} && sel_reset[~st_r.owner]
       && !sel_reset[st_r.owner] && sys_reset == 2'b00 && !isel_int_clear && !st_r.isel_int)
      |=> !isel_int_req && !adapter_reset;
  endproperty
  a_selother: assert property (p_selother) else $error("Non-owner selective reset acted");

  property p_bypass;
    @(posedge clock) disable iff (!resetn)
      (st_r.state == DCAS_NEUTRAL && (st_r.isel_int || st_r.ds_int) && rise_poll != 2'b00
       && sys_reset == 2'b00) |=> sel_bypass == $past(rise_poll);
  endproperty
  a_bypass: assert property (p_bypass) else $error("Poll not bypassed");
endmodule

// *** verif/dcas_host_model.sv ***
// Behavioural model of the two host channels driving Select Out
`timescale 1ns/1ps
module dcas_host_model (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [1:0] start,
  input wire logic [1:0] kind,
  input wire logic [1:0] done,
  output logic [1:0] sel_out,
  output logic [1:0] chan_init
);
  // ==========================================================
  // Select Out stands until the bench ends the sequence
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sel_out <= 2'b00;
      chan_init <= 2'b11;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (start[i]) begin
          sel_out[i] <= 1'b1;
          chan_init[i] <= kind[i];
        end else if (done[i]) begin
          // Invert a released line so a stale value is never trusted
          sel_out[i] <= 1'b0;
          chan_init[i] <= ~chan_init[i];
        end
      end
    end
  end
endmodule

// *** verif/dual_channel_allegiance_switch_test.sv ***
// Self-checking bench for the allegiance switch
`timescale 1ns/1ps
module dual_channel_allegiance_switch_test;
  import dcas_pkg::*;
  logic clock, resetn, cmd_accepted, cmd_is_tio, noop_unchained, zero_status_xfer;
  logic last_de_accepted, unit_check_end, ctl_cmd_decoded, status_accepted, status_stacked;
  logic async_setup, async_start, prog_int_pending, isel_int_clear, ds_int_clear;
  logic [1:0] if_enabled, allow_disable, panel_off, sys_reset, sel_reset, start, kind, done;
  logic [1:0] sel_out, chan_init, req_in, sel_bypass, sel_trap, connect, de_pending;
  logic [7:0] async_status, status_byte;
  logic status_valid, isel_int_req, ds_int_req, adapter_reset;
  logic [2:0] allegiance;
  logic [31:0] seed;
  logic [7:0] exp_q[$];
  int num_errors, check_count;

  dcas_host_model HOST (.clock, .resetn, .start, .kind, .done, .sel_out, .chan_init);
  dcas_switch DUT (.clock, .resetn, .if_enabled, .sel_out, .chan_init, .cmd_accepted,
    .cmd_is_tio, .noop_unchained, .zero_status_xfer, .last_de_accepted, .unit_check_end,
    .ctl_cmd_decoded, .status_accepted, .status_stacked, .async_setup, .async_start,
    .async_status, .prog_int_pending, .isel_int_clear, .ds_int_clear, .allow_disable,
    .panel_off, .sys_reset, .sel_reset, .req_in, .sel_bypass, .sel_trap, .connect,
    .status_byte, .status_valid, .isel_int_req, .ds_int_req, .adapter_reset, .allegiance,
    .de_pending);

  // ==========================================================
  // Clock and helpers
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic step;
    @(posedge clock);
    #1;
  endtask

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic sel(input int s, input logic ci);
    kind[s] = ci;
    start[s] = 1'b1;
    step;
    start[s] = 1'b0;
  endtask

  // Bounded wait for an answer; checks the connected side when asked
  task automatic wait_sv(input int s, input logic [1:0] cx);
    int n;
    n = 0;
    while (status_valid !== 1'b1 && n < 10) begin
      step;
      n++;
    end
    chk("answer", 8'h01, {7'h0, status_valid});
    if (cx != 2'b00) chk("connect", {6'h0, cx}, {6'h0, connect});
    done[s] = 1'b1;
    step;
    done[s] = 1'b0;
  endtask

  // A takes short allegiance, B is held, then A goes long and B is busied
  task automatic make_long;
    sel(0, 1'b1);
    repeat (3) step;
    chk("short", 8'h01, {5'h0, allegiance});
    sel(1, 1'b1);
    repeat (3) step;
    chk("trap", 8'h02, {6'h0, sel_trap});
    exp_q.push_back(8'h10);
    cmd_accepted = 1'b1;
    step;
    cmd_accepted = 1'b0;
    wait_sv(1, 2'b00);
    chk("long", 8'h02, {5'h0, allegiance});
    done[0] = 1'b1;
    step;
    done[0] = 1'b0;
  endtask

  // Every presented byte is compared with the model queue
  always @(posedge clock) begin
    if (status_valid === 1'b1 && exp_q.size() > 0) begin
      chk("status", exp_q.pop_front(), status_byte);
    end else if (status_valid === 1'b1) begin
      chk("status_extra", 8'h00, {7'h0, status_valid});
    end
  end

  task automatic results;
    chk("queue_left", 8'h00, 8'(exp_q.size()));
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Hang guard sized well beyond the scenario length
  initial begin
    #200000;
    num_errors++;
    results;
  end

  // ==========================================================
  // Scenarios
  initial begin
    {cmd_accepted, cmd_is_tio, noop_unchained, zero_status_xfer, last_de_accepted} = '0;
    {unit_check_end, ctl_cmd_decoded, status_accepted, status_stacked, async_setup} = '0;
    {async_start, prog_int_pending, isel_int_clear, ds_int_clear, async_status} = '0;
    {allow_disable, panel_off, sys_reset, sel_reset, start, kind, done} = '0;
    if_enabled = 2'b11;
    num_errors = 0;
    check_count = 0;
    seed = 32'h2ee2144c;
    resetn = 1'b0;
    repeat (6) @(posedge clock);
    #1;
    resetn = 1'b1;
    step;
    // Busy answer, then tagged Device End on the busied side
    make_long;
    last_de_accepted = 1'b1;
    step;
    last_de_accepted = 1'b0;
    repeat (3) step;
    chk("tagged", 8'h05, {5'h0, allegiance});
    chk("req_in", 8'h02, {6'h0, req_in});
    chk("de_pend", 8'h02, {6'h0, de_pending});
    exp_q.push_back(8'h04);
    sel(1, 1'b0);
    wait_sv(1, 2'b10);
    status_accepted = 1'b1;
    step;
    status_accepted = 1'b0;
    repeat (3) step;
    chk("neutral", 8'h00, {5'h0, allegiance});
    // Untagged status, first poller wins, then polls bypassed
    seed = xs(seed);
    async_status = seed[7:0];
    async_setup = 1'b1;
    step;
    async_setup = 1'b0;
    async_start = 1'b1;
    step;
    async_start = 1'b0;
    step;
    chk("untagged", 8'h04, {5'h0, allegiance});
    chk("req_both", 8'h03, {6'h0, req_in});
    exp_q.push_back(async_status);
    sel(0, 1'b0);
    wait_sv(0, 2'b01);
    status_accepted = 1'b1;
    step;
    status_accepted = 1'b0;
    step;
    chk("ds_int", 8'h01, {7'h0, ds_int_req});
    sel(1, 1'b0);
    repeat (2) step;
    chk("bypass", 8'h02, {6'h0, sel_bypass});
    done[1] = 1'b1;
    ds_int_clear = 1'b1;
    step;
    {done, ds_int_clear} = '0;
    // Pending status on selection, then control unit busy, both command kinds
    for (int t = 0; t < 2; t++) begin
      seed = xs(seed);
      async_status = seed[15:8];
      cmd_is_tio = t[0];
      async_setup = 1'b1;
      step;
      async_setup = 1'b0;
      exp_q.push_back(t == 1 ? async_status : async_status | 8'h10);
      sel(0, 1'b1);
      wait_sv(0, 2'b00);
      step;
      chk("isel_int", 8'h01, {7'h0, isel_int_req});
      exp_q.push_back(8'h70);
      sel(1, 1'b1);
      wait_sv(1, 2'b00);
      isel_int_clear = 1'b1;
      step;
      isel_int_clear = 1'b0;
    end
    cmd_is_tio = 1'b0;
    // Dual system reset
    sys_reset = 2'b11;
    step;
    chk("adp_rst", 8'h01, {7'h0, adapter_reset});
    sys_reset = 2'b00;
    repeat (2) step;
    chk("sys_both", 8'h01, {7'h0, isel_int_req});
    exp_q.push_back(8'h70);
    sel(1, 1'b1);
    wait_sv(1, 2'b00);
    isel_int_clear = 1'b1;
    step;
    isel_int_clear = 1'b0;
    // Resets on the side without allegiance, then selective reset on owner
    make_long;
    // A fresh selection on B during long allegiance is busied again
    exp_q.push_back(8'h10);
    sel(1, 1'b1);
    wait_sv(1, 2'b00);
    sys_reset = 2'b10;
    step;
    sys_reset = 2'b00;
    sel_reset = 2'b10;
    step;
    sel_reset = 2'b00;
    repeat (2) step;
    chk("kept", 8'h02, {5'h0, allegiance});
    chk("no_int", 8'h00, {7'h0, isel_int_req});
    sel_reset = 2'b01;
    step;
    sel_reset = 2'b00;
    repeat (2) step;
    chk("sel_rst", 8'h01, {7'h0, isel_int_req});
    chk("sr_neut", 8'h00, {5'h0, allegiance});
    isel_int_clear = 1'b1;
    step;
    isel_int_clear = 1'b0;
    repeat (4) step;
    chk("de_gone", 8'h00, {6'h0, req_in});
    results;
  end
endmodule
